// file: tmc_pkg.sv
// constants shared by the sixteen bit timer counter
package tmc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register word addresses
	localparam logic [3:0] ADDR_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h1;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
	localparam logic [3:0] ADDR_FLAG      = 4'h3;
	localparam logic [3:0] ADDR_ENABLE    = 4'h4;
	localparam logic [3:0] ADDR_CMP_LOW   = 4'h5;
	localparam logic [3:0] ADDR_CMP_HIGH  = 4'h6;
	localparam logic [3:0] ADDR_CMP_MODE  = 4'h7;
	localparam logic [3:0] ADDR_PORT_DIR  = 4'h8;
	localparam logic [3:0] ADDR_PORT_DATA = 4'h9;

	// counter_control fields, then the flag and enable register bits
	localparam int BIT_RUN      = 0;
	localparam int BIT_SRC      = 1;
	localparam int BIT_SYNC_BYP = 2;
	localparam int BIT_OSC_EN   = 3;
	localparam int BIT_DIV_LO   = 4;
	localparam int BIT_DIV_HI   = 5;
	localparam int BIT_OSC_RUN  = 6;
	localparam int BIT_WIDE     = 7;
	localparam int BIT_OVF      = 0;
	localparam int BIT_OVF_IE   = 0;

	// reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] CMP_RST    = 16'h0000;
	localparam logic [3:0] MODE_RST    = 4'h0;
	localparam logic [1:0] PORT_DIR_RST = 2'h3;

	// compare mode that fires the special event trigger
	localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;

	// instruction cycle is four oscillator cycles
	localparam int INSTR_DIV = 4;

	// input divider select codes
	typedef enum logic [1:0] {
		TMC_DIV_1 = 2'h0,
		TMC_DIV_2 = 2'h1,
		TMC_DIV_4 = 2'h2,
		TMC_DIV_8 = 2'h3
	} tmc_div_type;
	localparam logic [2:0] DIV_LIMIT_1 = 3'h0;
	localparam logic [2:0] DIV_LIMIT_2 = 3'h1;
	localparam logic [2:0] DIV_LIMIT_4 = 3'h3;
	localparam logic [2:0] DIV_LIMIT_8 = 3'h7;
endpackage

// file: tmc_prescaler.sv
// input divider placed between the count source and the counter
`timescale 1ns/1ps
module tmc_prescaler (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_tick,
	input  wire logic       i_clear,
	input  wire logic [1:0] i_sel,
	output logic            o_tick
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [2:0] limit;

	always_comb begin
		unique case (tmc_pkg::tmc_div_type'(i_sel))
			tmc_pkg::TMC_DIV_1: limit = tmc_pkg::DIV_LIMIT_1;
			tmc_pkg::TMC_DIV_2: limit = tmc_pkg::DIV_LIMIT_2;
			tmc_pkg::TMC_DIV_4: limit = tmc_pkg::DIV_LIMIT_4;
			tmc_pkg::TMC_DIV_8: limit = tmc_pkg::DIV_LIMIT_8;
		endcase
	end

	// one output per completed period
	assign o_tick = i_tick && !i_clear && (cnt >= limit);

	always_comb begin
		next_cnt = cnt;
		if (i_clear) begin
			next_cnt = 3'h0;
		end else if (i_tick) begin
			if (cnt >= limit) begin
				next_cnt = 3'h0;
			end else begin
				next_cnt = cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 3'h0;
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule

// file: tmc_timer.sv
// sixteen bit timer counter with compare trigger reset and wide access
//
// Overview of operation
// - source select 0 counts one per instruction cycle.
// - source select 1 counts rising edges of pin or oscillator.
// - oscillator enabled forces both pins to inputs reading zero.
// - compare mode 1011 trigger clears counter and starts conversion.
// - trigger clear never sets the overflow flag.
// - trigger reset only assured in timer or synchronised counter mode.
// - a counter write in the trigger cycle sets the bytes it loads; the trigger clears the rest.
// - compare pair acts as period, counter restarts at zero on match.
// - count wraps ffff to 0000 and latches overflow flag bit 0.
// - overflow request only while enable bit 0 is set.
// - wide mode high address hits buffer; low read copies high byte.
// - wide mode low write loads high from buffer, all bits together.
// - wide mode high writes keep prescaler; low writes clear it.
// - oscillator enable bit 3 starts the oscillator, runs in all modes.
// - divider select gives 1:1, 1:2, 1:4 or 1:8.
// - sync bypass 1 leaves external clock unsynchronised; 0 syncs.
// - run bit 0 enables counting, clear halts it.
// - internal source is oscillator clock divided by four.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module tmc_timer (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic [1:0] i_port_pin,
	output logic      [1:0] o_port_pin,
	output logic      [1:0] o_port_pin_oe,
	input  wire logic       i_osc_clk,
	input  wire logic       i_sys_clk_from_osc,
	input  wire logic       i_adc_enabled,
	output logic            o_osc_enable,
	output logic            o_overflow_irq,
	output logic            o_adc_start
);
	// register state
	logic [7:0]  counter_control;
	logic [7:0]  next_counter_control;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [7:0]  high_buffer;
	logic [7:0]  next_high_buffer;
	logic        overflow_flag;
	logic        next_overflow_flag;
	logic        overflow_irq_enable;
	logic        next_overflow_irq_enable;
	logic [15:0] compare_value;
	logic [15:0] next_compare_value;
	logic [3:0]  compare_mode_select;
	logic [3:0]  next_compare_mode_select;
	logic [1:0]  port_c_direction;
	logic [1:0]  next_port_c_direction;
	logic [1:0]  port_c_latch;
	logic [1:0]  next_port_c_latch;
	logic [7:0]  rdata;
	logic [7:0]  next_rdata;
	logic        adc_start;
	logic        next_adc_start;

	// count source and trigger state
	logic [1:0]  instr_div;
	logic [1:0]  next_instr_div;
	logic        sync_a;
	logic        sync_b;
	logic        sync_c;
	logic        raw_prev;
	logic        trig_armed;
	logic        next_trig_armed;

	// decoded fields
	logic        counter_run;
	logic        count_source_select;
	logic        ext_sync_bypass;
	logic        secondary_osc_enable;
	logic [1:0]  input_divider_select;
	logic        wide_access_enable;

	// strobes
	logic        wr_low;
	logic        wr_high;
	logic        rd_low;
	logic        instr_tick;
	logic        ext_raw;
	logic        ext_edge;
	logic        src_tick;
	logic        pre_clear;
	logic        count_tick;
	logic        match;
	logic        trigger;
	logic        trig_reset;
	logic [16:0] count_inc;
	logic [1:0]  pin_read;

	assign counter_run          = counter_control[tmc_pkg::BIT_RUN];
	assign count_source_select  = counter_control[tmc_pkg::BIT_SRC];
	assign ext_sync_bypass      = counter_control[tmc_pkg::BIT_SYNC_BYP];
	assign secondary_osc_enable = counter_control[tmc_pkg::BIT_OSC_EN];
	assign input_divider_select =
		counter_control[tmc_pkg::BIT_DIV_HI:tmc_pkg::BIT_DIV_LO];
	assign wide_access_enable   = counter_control[tmc_pkg::BIT_WIDE];

	assign wr_low  = i_wr && (i_addr == tmc_pkg::ADDR_COUNT_LOW);
	assign wr_high = i_wr && (i_addr == tmc_pkg::ADDR_COUNT_HIGH);
	assign rd_low  = i_rd && (i_addr == tmc_pkg::ADDR_COUNT_LOW);

	// instruction cycle enable from the oscillator clock
	assign instr_tick = (instr_div == 2'(tmc_pkg::INSTR_DIV - 1));

	always_comb begin
		next_instr_div = instr_div + 2'h1;
	end

	// oscillator output replaces the pin when enabled
	assign ext_raw = secondary_osc_enable ? i_osc_clk : i_port_pin[0];

	// bypass edge looks at the raw level; synchronised edge waits two
	// flops, trading two cycles of latency for a clean sample
	assign ext_edge = ext_sync_bypass ? (ext_raw && !raw_prev)
		: (sync_b && !sync_c);

	assign src_tick = count_source_select ? ext_edge : instr_tick;

	// narrow mode clears on either byte write, wide mode only on low
	assign pre_clear = wr_low
		|| (wr_high && !wide_access_enable);

	tmc_prescaler u_prescaler (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_tick  (src_tick),
		.i_clear (pre_clear),
		.i_sel   (input_divider_select),
		.o_tick  (count_tick)
	);

	// trigger fires once on entering a match, then rearms
	assign match = (count == compare_value)
		&& (compare_mode_select == tmc_pkg::MODE_SPECIAL_EVENT);
	assign trigger = match && trig_armed;

	// async counter mode does not honour the trigger
	assign trig_reset = trigger
		&& !(count_source_select && ext_sync_bypass);

	always_comb begin
		next_trig_armed = !match;
	end

	assign count_inc = {1'b0, count} + 17'h00001;

	always_comb begin
		next_count         = count;
		next_high_buffer   = high_buffer;
		next_overflow_flag = overflow_flag;
		if (counter_run && count_tick) begin
			next_count = count_inc[15:0];
		end
		if (trig_reset) begin
			// period restart, flag untouched
			next_count = tmc_pkg::COUNT_RST;
		end
		if (wr_low) begin
			// written bytes beat a coincident trigger, which still clears the high byte in narrow mode
			if (wide_access_enable) begin
				next_count = {high_buffer, i_wdata};
			end else begin
				next_count[7:0] = i_wdata;
			end
		end
		if (wr_high) begin
			if (wide_access_enable) begin
				next_high_buffer = i_wdata;
			end else begin
				next_count[15:8] = i_wdata;
			end
		end
		if (rd_low && wide_access_enable) begin
			next_high_buffer = count[15:8];
		end
		if (i_wr && (i_addr == tmc_pkg::ADDR_FLAG)) begin
			next_overflow_flag = i_wdata[tmc_pkg::BIT_OVF];
		end
		// a wrap in a trigger or clearing write cycle does not set the flag
		// a wide-mode high write only loads the buffer, so the wrap stands
		if (counter_run && count_tick && count_inc[16] && !trig_reset
			&& !wr_low && !(wr_high && !wide_access_enable)) begin
			next_overflow_flag = 1'b1;
		end
	end

	// software configuration registers
	always_comb begin
		next_counter_control     = counter_control;
		next_overflow_irq_enable = overflow_irq_enable;
		next_compare_value       = compare_value;
		next_compare_mode_select = compare_mode_select;
		next_port_c_direction    = port_c_direction;
		next_port_c_latch        = port_c_latch;
		if (i_wr) begin
			unique case (i_addr)
				tmc_pkg::ADDR_CONTROL: begin
					// status bit is read only
					next_counter_control = i_wdata;
					next_counter_control[tmc_pkg::BIT_OSC_RUN] = 1'b0;
				end
				tmc_pkg::ADDR_ENABLE: begin
					next_overflow_irq_enable = i_wdata[tmc_pkg::BIT_OVF_IE];
				end
				tmc_pkg::ADDR_CMP_LOW: begin
					next_compare_value[7:0] = i_wdata;
				end
				tmc_pkg::ADDR_CMP_HIGH: begin
					next_compare_value[15:8] = i_wdata;
				end
				tmc_pkg::ADDR_CMP_MODE: begin
					next_compare_mode_select = i_wdata[3:0];
				end
				tmc_pkg::ADDR_PORT_DIR: begin
					next_port_c_direction = i_wdata[1:0];
				end
				tmc_pkg::ADDR_PORT_DATA: begin
					next_port_c_latch = i_wdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// pins act as inputs and read zero under the oscillator
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			assign o_port_pin_oe[gi] = !secondary_osc_enable
				&& !port_c_direction[gi];
			assign o_port_pin[gi] = port_c_latch[gi];
			assign pin_read[gi] = !secondary_osc_enable && i_port_pin[gi];
		end
	endgenerate

	// read data stands in the cycle after the strobe; unmapped reads zero
	always_comb begin
		next_rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				tmc_pkg::ADDR_CONTROL: begin
					next_rdata = counter_control;
					next_rdata[tmc_pkg::BIT_OSC_RUN] = i_sys_clk_from_osc;
				end
				tmc_pkg::ADDR_COUNT_LOW: begin
					next_rdata = count[7:0];
				end
				tmc_pkg::ADDR_COUNT_HIGH: begin
					next_rdata = wide_access_enable ? high_buffer
						: count[15:8];
				end
				tmc_pkg::ADDR_FLAG: begin
					next_rdata[tmc_pkg::BIT_OVF] = overflow_flag;
				end
				tmc_pkg::ADDR_ENABLE: begin
					next_rdata[tmc_pkg::BIT_OVF_IE] = overflow_irq_enable;
				end
				tmc_pkg::ADDR_CMP_LOW: begin
					next_rdata = compare_value[7:0];
				end
				tmc_pkg::ADDR_CMP_HIGH: begin
					next_rdata = compare_value[15:8];
				end
				tmc_pkg::ADDR_CMP_MODE: begin
					next_rdata[3:0] = compare_mode_select;
				end
				tmc_pkg::ADDR_PORT_DIR: begin
					next_rdata[1:0] = port_c_direction;
				end
				tmc_pkg::ADDR_PORT_DATA: begin
					next_rdata[1:0] = pin_read;
				end
				default: begin
				end
			endcase
		end
	end

	// conversion start follows the trigger by one cycle
	always_comb begin
		next_adc_start = trig_reset && i_adc_enabled;
	end

	assign o_rdata        = rdata;
	assign o_adc_start    = adc_start;
	// oscillator runs whenever the bit is set, in any power mode;
	// start-up wait is left to software
	assign o_osc_enable   = secondary_osc_enable;
	assign o_overflow_irq = overflow_flag && overflow_irq_enable;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			counter_control     <= tmc_pkg::CONTROL_RST;
			count               <= tmc_pkg::COUNT_RST;
			high_buffer         <= 8'h00;
			overflow_flag       <= 1'b0;
			overflow_irq_enable <= 1'b0;
			compare_value       <= tmc_pkg::CMP_RST;
			compare_mode_select <= tmc_pkg::MODE_RST;
			port_c_direction    <= tmc_pkg::PORT_DIR_RST;
			port_c_latch        <= 2'h0;
			rdata               <= 8'h00;
			adc_start           <= 1'b0;
			instr_div           <= 2'h0;
			sync_a              <= 1'b0;
			sync_b              <= 1'b0;
			sync_c              <= 1'b0;
			raw_prev            <= 1'b0;
			trig_armed          <= 1'b1;
		end else begin
			counter_control     <= next_counter_control;
			count               <= next_count;
			high_buffer         <= next_high_buffer;
			overflow_flag       <= next_overflow_flag;
			overflow_irq_enable <= next_overflow_irq_enable;
			compare_value       <= next_compare_value;
			compare_mode_select <= next_compare_mode_select;
			port_c_direction    <= next_port_c_direction;
			port_c_latch        <= next_port_c_latch;
			rdata               <= next_rdata;
			adc_start           <= next_adc_start;
			instr_div           <= next_instr_div;
			sync_a              <= ext_raw;
			sync_b              <= sync_a;
			sync_c              <= sync_b;
			raw_prev            <= ext_raw;
			trig_armed          <= next_trig_armed;
		end
	end
endmodule

// file: tmc_checker.sv
// port level assertions for the timer counter
`timescale 1ns/1ps
module tmc_checker (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [1:0] i_port_pin,
	input wire logic [1:0] o_port_pin,
	input wire logic [1:0] o_port_pin_oe,
	input wire logic       i_osc_clk,
	input wire logic       i_sys_clk_from_osc,
	input wire logic       i_adc_enabled,
	input wire logic       o_osc_enable,
	input wire logic       o_overflow_irq,
	input wire logic       o_adc_start
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	irq_mask_a: assert property (
		i_wr && i_addr == tmc_pkg::ADDR_ENABLE && !i_wdata[0] |=> !o_overflow_irq)
		else $error("request with enable clear");
	adc_gate_a: assert property (o_adc_start |-> $past(i_adc_enabled))
		else $error("conversion start while converter off");
	adc_pulse_a: assert property (o_adc_start |=> !o_adc_start)
		else $error("conversion start longer than a cycle");
	osc_enable_a: assert property (
		i_wr && i_addr == tmc_pkg::ADDR_CONTROL |=> o_osc_enable == $past(i_wdata[3]))
		else $error("oscillator enable not taken");
	pin_input_a: assert property (o_osc_enable |-> o_port_pin_oe == 2'h0)
		else $error("pin driven while oscillator on");
	port_zero_a: assert property (
		$past(i_rd && i_addr == tmc_pkg::ADDR_PORT_DATA && o_osc_enable) |-> o_rdata == 8'h00)
		else $error("pins not read as zero");
	unmapped_read_a: assert property ($past(i_rd && i_addr > 4'h9) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind tmc_timer tmc_checker chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_port_pin, .o_port_pin, .o_port_pin_oe, .i_osc_clk, .i_sys_clk_from_osc,
	.i_adc_enabled, .o_osc_enable, .o_overflow_irq, .o_adc_start);

// file: tmc_partner.sv
// far side source: external count pin and secondary oscillator
`timescale 1ns/1ps
module tmc_partner (
	input  wire logic i_clk,
	input  wire logic i_go,
	output logic      o_pin = 1'b0,
	output logic      o_osc
);
	logic [1:0] phase = 2'h0;
	// one rising edge every eight clocks; held low between runs
	always @(posedge i_clk) begin
		phase <= i_go ? phase + 2'h1 : 2'h0;
		if (!i_go)
			o_pin <= 1'b0;
		else if (phase == 2'h3)
			o_pin <= ~o_pin;
	end
	assign o_osc = o_pin;
endmodule

// file: tb_tmc_timer.sv
// self-checking bench for the timer counter
`timescale 1ns/1ps
module tb_tmc_timer;
	logic       i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, go = 0, pin1 = 0, adc_en = 0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, o_rdata, a, b, h, l;
	logic [1:0] oe, p_out;
	logic       p_pin, p_osc, osc_en, irq, adc_start;
	int         err_count = 0, cmp_count = 0, cyc = 0, pulses = 0, m, p;
	int         mdl [16];

	tmc_partner far (.i_clk(i_clk), .i_go(go), .o_pin(p_pin), .o_osc(p_osc));
	tmc_timer dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_pin({pin1, p_pin}),
		.o_port_pin(p_out), .o_port_pin_oe(oe), .i_osc_clk(p_osc),
		.i_sys_clk_from_osc(1'b0), .i_adc_enabled(adc_en), .o_osc_enable(osc_en),
		.o_overflow_irq(irq), .o_adc_start(adc_start));

	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (adc_start === 1'b1)
			pulses++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		mdl[ad] = int'(d) & msk(ad);
	endtask
	task automatic rd(input logic [3:0] ad, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		if (msk(ad) != 0 || ad > tmc_pkg::ADDR_PORT_DATA)
			chk(d, 16'(mdl[ad]));
	endtask
	// readable bits of the plain registers; status bit 6 reads the tied-low input
	function automatic int msk(input logic [3:0] ad);
		case (ad)
			tmc_pkg::ADDR_CONTROL: return 32'hbf;
			tmc_pkg::ADDR_ENABLE: return 32'h01;
			tmc_pkg::ADDR_CMP_LOW, tmc_pkg::ADDR_CMP_HIGH: return 32'hff;
			tmc_pkg::ADDR_CMP_MODE: return 32'h0f;
			tmc_pkg::ADDR_PORT_DIR: return 32'h03;
			default: return 0;
		endcase
	endfunction
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		void'($urandom(32'hf68b));
		mdl[tmc_pkg::ADDR_PORT_DIR] = int'(tmc_pkg::PORT_DIR_RST);
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(tmc_pkg::ADDR_CONTROL, a); chk(a, 8'h00);
		rd(tmc_pkg::ADDR_PORT_DIR, a); chk(a, 8'h03);
		rd(4'hc, a); chk(a, 8'h00);
		pin1 <= 1'b1;
		rd(tmc_pkg::ADDR_PORT_DATA, a); chk(a, 8'h02);
		wr(tmc_pkg::ADDR_PORT_DIR, 8'h00);
		#1 chk(oe, 2'h3);
		wr(tmc_pkg::ADDR_PORT_DATA, 8'h02);
		#1 chk(p_out, 2'h2);
		wr(tmc_pkg::ADDR_CONTROL, 8'h08);
		#1 chk(oe, 2'h0);
		chk(osc_en, 1'b1);
		rd(tmc_pkg::ADDR_PORT_DATA, a); chk(a, 8'h00);
		$display("test pins done");
		// snapshots a whole number of count periods apart differ by exactly m
		go <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 4; d++) begin
				m = 1 + $urandom % 5;
				p = ((s == 0) ? 4 : 8) << d;
				wr(tmc_pkg::ADDR_CONTROL, {2'b00, d[1:0], s == 3, s == 2, s != 0, 1'b1});
				repeat (40) @(posedge i_clk);
				rd(tmc_pkg::ADDR_COUNT_LOW, a);
				repeat (p * m - 2) @(posedge i_clk);
				rd(tmc_pkg::ADDR_COUNT_LOW, b);
				chk(16'(8'(b - a)), 16'(m));
			end
		end
		go <= 1'b0;
		$display("test sources done");
		h = $urandom;
		l = $urandom;
		wr(tmc_pkg::ADDR_CONTROL, 8'h80);
		wr(tmc_pkg::ADDR_COUNT_HIGH, h);
		wr(tmc_pkg::ADDR_COUNT_LOW, l);
		wr(tmc_pkg::ADDR_COUNT_HIGH, ~h);
		wr(tmc_pkg::ADDR_CONTROL, 8'h00);
		rd(tmc_pkg::ADDR_COUNT_HIGH, a); chk(a, h);
		rd(tmc_pkg::ADDR_COUNT_LOW, a); chk(a, l);
		wr(tmc_pkg::ADDR_COUNT_HIGH, h ^ 8'h5a);
		wr(tmc_pkg::ADDR_CONTROL, 8'h80);
		rd(tmc_pkg::ADDR_COUNT_LOW, a); chk(a, l);
		rd(tmc_pkg::ADDR_COUNT_HIGH, a); chk(a, h ^ 8'h5a);
		// 1:8 internal: one count per 32 clocks; high writes every 2 clocks
		// must not hold the divider back, so two counts land in 82 clocks
		wr(tmc_pkg::ADDR_CONTROL, 8'hb1);
		wr(tmc_pkg::ADDR_COUNT_LOW, 8'h00);
		repeat (40) wr(tmc_pkg::ADDR_COUNT_HIGH, h);
		wr(tmc_pkg::ADDR_CONTROL, 8'h80);
		rd(tmc_pkg::ADDR_COUNT_LOW, a); chk(a, 8'h02);
		$display("test wide access done");
		wr(tmc_pkg::ADDR_CONTROL, 8'h00);
		wr(tmc_pkg::ADDR_COUNT_HIGH, 8'hff);
		wr(tmc_pkg::ADDR_COUNT_LOW, 8'hfd);
		wr(tmc_pkg::ADDR_FLAG, 8'h00);
		wr(tmc_pkg::ADDR_ENABLE, 8'h01);
		wr(tmc_pkg::ADDR_CONTROL, 8'h01);
		repeat (20) @(posedge i_clk);
		wr(tmc_pkg::ADDR_CONTROL, 8'h00);
		rd(tmc_pkg::ADDR_FLAG, a); chk(a, 8'h01);
		chk(irq, 1'b1);
		rd(tmc_pkg::ADDR_COUNT_HIGH, a); chk(a, 8'h00);
		wr(tmc_pkg::ADDR_ENABLE, 8'h00);
		#1 chk(irq, 1'b0);
		$display("test overflow done");
		wr(tmc_pkg::ADDR_FLAG, 8'h00);
		wr(tmc_pkg::ADDR_CMP_LOW, 8'h10);
		wr(tmc_pkg::ADDR_CMP_HIGH, 8'h00);
		wr(tmc_pkg::ADDR_CMP_MODE, 8'h0b);
		wr(tmc_pkg::ADDR_COUNT_LOW, 8'h00);
		adc_en <= 1'b1;
		pulses = 0;
		wr(tmc_pkg::ADDR_CONTROL, 8'h01);
		repeat (300) @(posedge i_clk);
		wr(tmc_pkg::ADDR_CONTROL, 8'h00);
		chk(16'(pulses), 16'h0004);
		rd(tmc_pkg::ADDR_FLAG, a); chk(a, 8'h00);
		rd(tmc_pkg::ADDR_COUNT_LOW, a); chk(16'(a <= 8'h10), 16'h0001);
		// back-to-back writes: the second lands in the cycle the first makes a match
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= tmc_pkg::ADDR_COUNT_LOW;
		i_wdata <= 8'h10;
		@(posedge i_clk);
		i_wdata <= 8'h55;
		@(posedge i_clk);
		i_wr <= 1'b0;
		rd(tmc_pkg::ADDR_COUNT_LOW, a); chk(a, 8'h55);
		$display("test trigger done");
		tally_and_finish();
	end
endmodule
